/* load_setpoint_sequencer_defines.svh */
// Register map, field positions, reset values and timing for the setpoint sequencer
`ifndef LOAD_SETPOINT_SEQUENCER_DEFINES_SVH
`define LOAD_SETPOINT_SEQUENCER_DEFINES_SVH

// ==========================================================================
// Register byte offsets
`define REG_CTRL        8'h00
`define REG_LEVEL_A     8'h04
`define REG_HOLD_A      8'h08
`define REG_RISE        8'h0c
`define REG_LEVEL_B     8'h10
`define REG_HOLD_B      8'h14
`define REG_FALL        8'h18
`define REG_LIST_CFG    8'h1c
`define REG_STEP_IDX    8'h20
`define REG_STEP_DATA   8'h24
`define REG_STATUS      8'h28
`define REG_SLOT_KIND   8'h2c

// ==========================================================================
// Control fields
`define CTRL_TRAN_EN    0
`define CTRL_LIST_START 1
`define CTRL_LIST_STOP  2
`define CTRL_SW_TRIG    3
`define CTRL_MODE_LO    4
`define CTRL_MODE_HI    5
`define CTRL_SLOT_LO    8
`define CTRL_SLOT_HI    10

// ==========================================================================
// List config fields: time base, end behaviour, step count
`define CFG_TB_HI       15
`define CFG_END_LO      16
`define CFG_END_HI      17
`define CFG_CNT_LO      24
`define CFG_CNT_HI      31

// ==========================================================================
// Sizes and reset values
`define NUM_SLOTS       8
`define MAX_STEPS       200
`define MEM_WORDS       1600
`define TB_RESET        16'h0001
`define CNT_RESET       8'h01

// ==========================================================================
// Timing: 20 us time unit and 5 ms external trigger qualification
`define CLK_PERIOD_NS   10
`define TICK_NS         20000
`define TICK_CYC        (`TICK_NS / `CLK_PERIOD_NS)
`define EXT_TRIG_MIN_NS 5000000
`define EXT_TRIG_CYC    (`EXT_TRIG_MIN_NS / `CLK_PERIOD_NS)

`endif

/* load_setpoint_sequencer_pkg.sv */
// Types shared by the setpoint sequencer
package load_setpoint_sequencer_pkg;

	typedef enum logic [1:0] {
		MODE_CONTINUOUS = 2'b00,
		MODE_PULSE      = 2'b01,
		MODE_TOGGLE     = 2'b10
	} transient_mode_select_e;

	typedef enum logic [1:0] {
		END_LOOP  = 2'b00,
		END_HOLD  = 2'b01,
		END_RESET = 2'b10
	} list_end_e;

	typedef enum logic [2:0] {
		T_HOLD_A  = 3'b000,
		T_RAMP_UP = 3'b001,
		T_HOLD_B  = 3'b010,
		T_RAMP_DN = 3'b011
	} tran_state_e;

	typedef enum logic [1:0] {
		L_IDLE  = 2'b00,
		L_FETCH = 2'b01,
		L_RUN   = 2'b10,
		L_HOLD  = 2'b11
	} list_state_e;

endpackage

/* load_setpoint_sequencer.sv */
// Load setpoint sequencer: transient generator, list player and APB registers
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/100ps
`include "load_setpoint_sequencer_defines.svh"

module load_setpoint_sequencer
	import load_setpoint_sequencer_pkg::*;
#(
	parameter int unsigned EXT_TRIG_MIN_CYC = `EXT_TRIG_CYC
) (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	// APB slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic             o_pready,
	output logic [31:0]      o_prdata,
	output logic             o_pslverr,
	// Trigger sources
	input  wire logic        i_key_trig,
	input  wire logic        i_ext_trig,
	// Load drive
	output logic [15:0]      o_setpoint,
	output logic             o_load_on
);

	// ======================================================================
	// Functions
	function automatic logic [10:0] mem_addr(input logic [2:0] slot, input logic [7:0] idx);
		mem_addr = 11'(slot * `MAX_STEPS + idx);
	endfunction

	// True when a counter at cnt finishes a span of len units with this unit
	function automatic logic span_done(input logic [15:0] cnt, input logic [15:0] len);
		span_done = ({1'b0, cnt} + 17'h00001) >= {1'b0, len};
	endfunction

	function automatic logic [15:0] lerp(input logic [15:0] a, input logic [15:0] b,
	                                     input logic [15:0] k, input logic [15:0] n);
		logic signed [17:0] diff;
		logic signed [35:0] prod;
		logic signed [35:0] sum;
		diff = $signed({2'b00, b}) - $signed({2'b00, a});
		prod = (diff * $signed({2'b00, k})) / $signed({20'h00000, n});
		sum  = $signed({20'h00000, a}) + prod;
		lerp = sum[15:0];
	endfunction

	// ======================================================================
	// Register state
	logic                   tran_en_q;
	transient_mode_select_e mode_q;
	logic [2:0]             slot_q;
	logic [15:0]            level_a_q;
	logic [15:0]            hold_a_q;
	logic [15:0]            rise_q;
	logic [15:0]            level_b_q;
	logic [15:0]            level_b_hold_time_q;
	logic [15:0]            fall_q;
	logic [7:0]             step_idx_q;
	logic [7:0]             slot_kind_q;
	logic [15:0]            list_time_base_q [`NUM_SLOTS];
	logic [1:0]             list_end_q [`NUM_SLOTS];
	logic [7:0]             list_step_count_q [`NUM_SLOTS];
	logic [31:0]            step_mem [`MEM_WORDS];
	logic                   list_start_q;
	logic                   list_stop_q;
	logic                   sw_trig_q;

	logic                   wr_en;
	logic                   rd_en;
	logic                   mapped;
	logic [31:0]            rd_data;

	// Write commits at the edge where pready is seen high; read data is taken one edge earlier
	assign wr_en  = i_psel & i_penable & o_pready & i_pwrite;
	assign rd_en  = i_psel & i_penable & ~o_pready & ~i_pwrite;
	assign mapped = (i_paddr <= `REG_SLOT_KIND) && (i_paddr[1:0] == 2'b00);

	// ======================================================================
	// APB handshake: one wait state, then answer
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_pready  <= 1'b0;
			o_prdata  <= 32'h00000000;
			o_pslverr <= 1'b0;
		end else begin
			o_pready  <= i_psel & i_penable & ~o_pready;
			o_pslverr <= i_psel & i_penable & ~o_pready & ~mapped;
			if (rd_en) begin
				o_prdata <= mapped ? rd_data : 32'h00000000;
			end
		end
	end

	// ======================================================================
	// Transient settings and control
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tran_en_q           <= 1'b0;
			mode_q              <= MODE_CONTINUOUS;
			slot_q              <= 3'h0;
			level_a_q           <= 16'h0000;
			hold_a_q            <= 16'h0000;
			rise_q              <= 16'h0000;
			level_b_q           <= 16'h0000;
			level_b_hold_time_q <= 16'h0000;
			fall_q              <= 16'h0000;
			list_start_q        <= 1'b0;
			list_stop_q         <= 1'b0;
			sw_trig_q           <= 1'b0;
		end else begin
			list_start_q <= 1'b0;
			list_stop_q  <= 1'b0;
			sw_trig_q    <= 1'b0;
			if (wr_en) begin
				case (i_paddr)
					`REG_CTRL: begin
						tran_en_q    <= i_pwdata[`CTRL_TRAN_EN];
						mode_q       <= transient_mode_select_e'(i_pwdata[`CTRL_MODE_HI:`CTRL_MODE_LO]);
						slot_q       <= i_pwdata[`CTRL_SLOT_HI:`CTRL_SLOT_LO];
						list_start_q <= i_pwdata[`CTRL_LIST_START];
						list_stop_q  <= i_pwdata[`CTRL_LIST_STOP];
						sw_trig_q    <= i_pwdata[`CTRL_SW_TRIG];
					end
					`REG_LEVEL_A: level_a_q <= i_pwdata[15:0];
					`REG_HOLD_A:  hold_a_q  <= i_pwdata[15:0];
					`REG_RISE:    rise_q    <= i_pwdata[15:0];
					`REG_LEVEL_B: level_b_q <= i_pwdata[15:0];
					`REG_HOLD_B:  level_b_hold_time_q <= i_pwdata[15:0];
					`REG_FALL:    fall_q    <= i_pwdata[15:0];
					default: begin
					end
				endcase
			end
		end
	end

	// ======================================================================
	// List storage; step index auto-advances after each data write
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			step_idx_q  <= 8'h00;
			slot_kind_q <= 8'h00;
		end else if (wr_en) begin
			case (i_paddr)
				`REG_STEP_IDX: step_idx_q <= i_pwdata[7:0];
				`REG_STEP_DATA: begin
					step_idx_q          <= (step_idx_q == 8'(`MAX_STEPS - 1)) ? 8'h00 :
					                       step_idx_q + 8'h01;
					slot_kind_q[slot_q] <= 1'b1;
				end
				`REG_LIST_CFG: slot_kind_q[slot_q] <= 1'b1;
				`REG_SLOT_KIND: slot_kind_q <= i_pwdata[7:0];
				default: begin
				end
			endcase
		end
	end

	// Large table carries no reset so it can map onto block memory
	always_ff @(posedge i_clk) begin
		if (wr_en && i_paddr == `REG_STEP_DATA && step_idx_q < 8'(`MAX_STEPS)) begin
			step_mem[mem_addr(slot_q, step_idx_q)] <= i_pwdata;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int s = 0; s < `NUM_SLOTS; s++) begin
				list_time_base_q[s]  <= `TB_RESET;
				list_end_q[s]        <= END_LOOP;
				list_step_count_q[s] <= `CNT_RESET;
			end
		end else if (wr_en && i_paddr == `REG_LIST_CFG) begin
			list_time_base_q[slot_q]  <= i_pwdata[`CFG_TB_HI:0];
			list_end_q[slot_q]        <= i_pwdata[`CFG_END_HI:`CFG_END_LO];
			list_step_count_q[slot_q] <= i_pwdata[`CFG_CNT_HI:`CFG_CNT_LO];
		end
	end

	// ======================================================================
	// 20 us tick
	logic [15:0] tick_cnt_q;
	logic        tick_q;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tick_cnt_q <= 16'h0000;
			tick_q     <= 1'b0;
		end else begin
			tick_q     <= (tick_cnt_q == 16'(`TICK_CYC - 1));
			tick_cnt_q <= (tick_cnt_q == 16'(`TICK_CYC - 1)) ? 16'h0000 : tick_cnt_q + 16'h0001;
		end
	end

	// ======================================================================
	// Trigger merge; rear input fires once after it has stayed high long enough
	logic [19:0] ext_cnt_q;
	logic        ext_fire_q;
	logic        key_q;
	logic        trig;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ext_cnt_q  <= 20'h00000;
			ext_fire_q <= 1'b0;
			key_q      <= 1'b0;
		end else begin
			key_q      <= i_key_trig;
			ext_fire_q <= i_ext_trig && (ext_cnt_q == 20'(EXT_TRIG_MIN_CYC));
			if (!i_ext_trig) begin
				ext_cnt_q <= 20'h00000;
			end else if (ext_cnt_q <= 20'(EXT_TRIG_MIN_CYC)) begin
				ext_cnt_q <= ext_cnt_q + 20'h00001;
			end
		end
	end

	// Key is edge detected so a held key counts once
	assign trig = (i_key_trig & ~key_q) | ext_fire_q | sw_trig_q;

	// ======================================================================
	// Transient generator
	tran_state_e tstate_q;
	logic [15:0] tcnt_q;
	logic [15:0] tsp_q;
	logic        cont;
	logic        all_zero;

	assign cont     = (mode_q == MODE_CONTINUOUS);
	assign all_zero = (hold_a_q | rise_q | level_b_hold_time_q | fall_q) == 16'h0000;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tstate_q <= T_HOLD_A;
			tcnt_q   <= 16'h0000;
			tsp_q    <= 16'h0000;
		end else if (!tran_en_q) begin
			tstate_q <= T_HOLD_A;
			tcnt_q   <= 16'h0000;
			tsp_q    <= level_a_q;
		end else begin
			case (tstate_q)
				T_HOLD_A: begin
					tsp_q <= level_a_q;
					// Zero-length spans pass in one clock so periods stay exact
					if (cont && !all_zero) begin
						if (hold_a_q == 16'h0000 || (tick_q && span_done(tcnt_q, hold_a_q))) begin
							tstate_q <= T_RAMP_UP;
							tcnt_q   <= 16'h0000;
						end else if (tick_q) begin
							tcnt_q <= tcnt_q + 16'h0001;
						end
					end else if (!cont && trig) begin
						tstate_q <= T_RAMP_UP;
						tcnt_q   <= 16'h0000;
					end
				end
				T_RAMP_UP: begin
					if (rise_q == 16'h0000) begin
						tstate_q <= T_HOLD_B;
					end else if (tick_q) begin
						tsp_q <= lerp(level_a_q, level_b_q, tcnt_q + 16'h0001, rise_q);
						if (span_done(tcnt_q, rise_q)) begin
							tstate_q <= T_HOLD_B;
							tcnt_q   <= 16'h0000;
						end else begin
							tcnt_q <= tcnt_q + 16'h0001;
						end
					end
				end
				T_HOLD_B: begin
					tsp_q <= level_b_q;
					if (mode_q == MODE_TOGGLE) begin
						if (trig) begin
							tstate_q <= T_RAMP_DN;
							tcnt_q   <= 16'h0000;
						end
					end else if (level_b_hold_time_q == 16'h0000 ||
					             (tick_q && span_done(tcnt_q, level_b_hold_time_q))) begin
						tstate_q <= T_RAMP_DN;
						tcnt_q   <= 16'h0000;
					end else if (tick_q) begin
						tcnt_q <= tcnt_q + 16'h0001;
					end
				end
				T_RAMP_DN: begin
					if (fall_q == 16'h0000) begin
						tstate_q <= T_HOLD_A;
					end else if (tick_q) begin
						tsp_q <= lerp(level_b_q, level_a_q, tcnt_q + 16'h0001, fall_q);
						if (span_done(tcnt_q, fall_q)) begin
							tstate_q <= T_HOLD_A;
							tcnt_q   <= 16'h0000;
						end else begin
							tcnt_q <= tcnt_q + 16'h0001;
						end
					end
				end
				default: begin
					tstate_q <= T_HOLD_A;
				end
			endcase
		end
	end

	// ======================================================================
	// List sequencer
	list_state_e lstate_q;
	logic [2:0]  run_slot_q;
	logic [7:0]  run_idx_q;
	logic [31:0] step_q;
	logic [15:0] base_cnt_q;
	logic [15:0] dur_cnt_q;
	logic        list_off_q;
	logic        last_step;

	assign last_step = ({1'b0, run_idx_q} + 9'h001) >= {1'b0, list_step_count_q[run_slot_q]};

	always_ff @(posedge i_clk) begin
		step_q <= step_mem[mem_addr(run_slot_q, run_idx_q)];
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			lstate_q   <= L_IDLE;
			run_slot_q <= 3'h0;
			run_idx_q  <= 8'h00;
			base_cnt_q <= 16'h0000;
			dur_cnt_q  <= 16'h0000;
			list_off_q <= 1'b0;
		end else if (list_stop_q) begin
			lstate_q <= L_IDLE;
		end else if (list_start_q) begin
			lstate_q   <= L_FETCH;
			run_slot_q <= slot_q;
			run_idx_q  <= 8'h00;
			list_off_q <= 1'b0;
		end else begin
			case (lstate_q)
				L_FETCH: begin
					lstate_q   <= L_RUN;
					base_cnt_q <= 16'h0000;
					dur_cnt_q  <= 16'h0000;
				end
				L_RUN: begin
					if (tick_q) begin
						if (!span_done(base_cnt_q, list_time_base_q[run_slot_q])) begin
							base_cnt_q <= base_cnt_q + 16'h0001;
						end else begin
							base_cnt_q <= 16'h0000;
							if (!span_done(dur_cnt_q, step_q[31:16])) begin
								dur_cnt_q <= dur_cnt_q + 16'h0001;
							end else if (!last_step) begin
								run_idx_q <= run_idx_q + 8'h01;
								lstate_q  <= L_FETCH;
							end else begin
								case (list_end_e'(list_end_q[run_slot_q]))
									END_HOLD: lstate_q <= L_HOLD;
									END_RESET: begin
										lstate_q   <= L_IDLE;
										list_off_q <= 1'b1;
									end
									default: begin
										run_idx_q <= 8'h00;
										lstate_q  <= L_FETCH;
									end
								endcase
							end
						end
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ======================================================================
	// Output drive; a running or holding list takes priority over transients
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_setpoint <= 16'h0000;
			o_load_on  <= 1'b0;
		end else begin
			if (lstate_q == L_RUN || lstate_q == L_HOLD) begin
				o_setpoint <= step_q[15:0];
			end else if (lstate_q == L_FETCH) begin
				// Keep the last current while the next step is fetched, no dip to zero
				o_setpoint <= o_setpoint;
			end else if (tran_en_q) begin
				o_setpoint <= tsp_q;
			end else begin
				o_setpoint <= 16'h0000;
			end
			o_load_on <= tran_en_q || (lstate_q != L_IDLE);
		end
	end

	// ======================================================================
	// Read mux
	always_comb begin
		rd_data = 32'h00000000;
		case (i_paddr)
			`REG_CTRL: begin
				rd_data[`CTRL_TRAN_EN]                 = tran_en_q;
				rd_data[`CTRL_MODE_HI:`CTRL_MODE_LO]   = mode_q;
				rd_data[`CTRL_SLOT_HI:`CTRL_SLOT_LO]   = slot_q;
			end
			`REG_LEVEL_A:   rd_data[15:0] = level_a_q;
			`REG_HOLD_A:    rd_data[15:0] = hold_a_q;
			`REG_RISE:      rd_data[15:0] = rise_q;
			`REG_LEVEL_B:   rd_data[15:0] = level_b_q;
			`REG_HOLD_B:    rd_data[15:0] = level_b_hold_time_q;
			`REG_FALL:      rd_data[15:0] = fall_q;
			`REG_LIST_CFG: begin
				rd_data[`CFG_TB_HI:0]              = list_time_base_q[slot_q];
				rd_data[`CFG_END_HI:`CFG_END_LO]   = list_end_q[slot_q];
				rd_data[`CFG_CNT_HI:`CFG_CNT_LO]   = list_step_count_q[slot_q];
			end
			`REG_STEP_IDX:  rd_data[7:0] = step_idx_q;
			`REG_STEP_DATA: rd_data = (step_idx_q < 8'(`MAX_STEPS)) ?
			                          step_mem[mem_addr(slot_q, step_idx_q)] : 32'h00000000;
			`REG_STATUS: begin
				rd_data[15:0]  = o_setpoint;
				rd_data[18:16] = tstate_q;
				rd_data[21:20] = lstate_q;
				rd_data[22]    = o_load_on;
				rd_data[23]    = list_off_q;
				rd_data[31:24] = run_idx_q;
			end
			`REG_SLOT_KIND: rd_data[7:0] = slot_kind_q;
			default: rd_data = 32'h00000000;
		endcase
	end

endmodule

/* load_setpoint_sequencer_assertions.sv */
// Port-level assertions for the setpoint sequencer
`timescale 1ns/100ps
module load_setpoint_sequencer_assertions #(
	parameter int unsigned EXT_TRIG_MIN_CYC = 20
) (
	// Clock and reset
	input wire logic        i_clk,
	input wire logic        i_rst_b,
	// APB
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [7:0]  i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic        o_pready,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pslverr,
	// Triggers and load drive
	input wire logic        i_key_trig,
	input wire logic        i_ext_trig,
	input wire logic [15:0] o_setpoint,
	input wire logic        o_load_on
);
	// ==========================================================================
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	a_pready_one_wait: assert property ($rose(i_penable) && i_psel |-> !o_pready ##1 o_pready)
		else $error("pready not after exactly one wait state");
	a_pready_single: assert property (o_pready |=> !o_pready)
		else $error("pready held longer than one cycle");
	a_pready_in_access: assert property (o_pready |-> i_psel && i_penable)
		else $error("pready outside an access phase");
	a_err_with_ready: assert property (o_pslverr |-> o_pready)
		else $error("pslverr without pready");
	a_bad_addr_err: assert property (o_pready && (i_paddr > 8'h2c || i_paddr[1:0] != 2'h0)
		|-> o_pslverr)
		else $error("unmapped address not refused");
	a_good_addr_ok: assert property (o_pready && i_paddr <= 8'h2c && i_paddr[1:0] == 2'h0
		|-> !o_pslverr)
		else $error("mapped address refused");
	a_bad_read_zero: assert property (o_pready && o_pslverr && !i_pwrite
		|-> o_prdata == 32'h0000_0000)
		else $error("refused read returned data");
	a_reset_quiet: assert property ($rose(i_rst_b) |-> o_setpoint == 16'h0000 && !o_load_on)
		else $error("outputs active right after reset");
endmodule

bind load_setpoint_sequencer load_setpoint_sequencer_assertions #(
	.EXT_TRIG_MIN_CYC(EXT_TRIG_MIN_CYC)
) u_assert (
	.i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable),
	.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
	.o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_key_trig(i_key_trig),
	.i_ext_trig(i_ext_trig), .o_setpoint(o_setpoint), .o_load_on(o_load_on)
);

/* ext_trig_source.sv */
// Rear trigger source model: level pulses of a chosen width in clocks
`timescale 1ns/100ps
module ext_trig_source (
	// Clock
	input  wire logic        i_clk,
	// Bench control
	input  wire logic        i_go,
	input  wire logic [15:0] i_width,
	// Trigger line, low when idle
	output logic             o_trig
);
	logic [15:0] left_q = 16'h0000;

	// Short widths are commanded only to see runt pulses refused
	always_ff @(posedge i_clk) begin
		if (i_go) begin
			left_q <= i_width;
		end else if (left_q != 16'h0000) begin
			left_q <= left_q - 16'h0001;
		end
	end
	assign o_trig = (left_q != 16'h0000);
endmodule

/* load_setpoint_sequencer_tb.sv */
// Self-checking testbench for the setpoint sequencer
`timescale 1ns/100ps
`include "load_setpoint_sequencer_defines.svh"
module load_setpoint_sequencer_tb
	import load_setpoint_sequencer_pkg::*;
;
	localparam int TK = `TICK_CYC;
	typedef struct packed {
		logic        wr;
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] x;
		logic        e;
	} row_s;

	logic        i_clk, i_rst_b, psel, penable, pwrite, pready, pslverr;
	logic        key_trig, ext_go, ext_trig, load_on;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] setpoint, ext_width;
	logic        er;
	int          n_mismatch = 0;
	int          checks_done = 0;
	int          waited, t;
	row_s        rows [11] = '{
		'{1'b0, `REG_CTRL, 32'h0, 32'h0000_0000, 1'b0},
		'{1'b0, `REG_LIST_CFG, 32'h0, 32'h0100_0001, 1'b0},
		'{1'b0, `REG_HOLD_A, 32'h0, 32'h0000_0000, 1'b0},
		'{1'b1, `REG_LEVEL_A, 32'hffff_1234, 32'h0, 1'b0},
		'{1'b0, `REG_LEVEL_A, 32'h0, 32'h0000_1234, 1'b0},
		'{1'b1, `REG_CTRL, 32'h0000_0029, 32'h0, 1'b0},
		'{1'b0, `REG_CTRL, 32'h0, 32'h0000_0021, 1'b0},
		'{1'b1, `REG_CTRL, 32'h0000_0000, 32'h0, 1'b0},
		'{1'b1, 8'h30, 32'h5555_aaaa, 32'h0, 1'b1},
		'{1'b0, 8'h30, 32'h0, 32'h0000_0000, 1'b1},
		'{1'b0, 8'h06, 32'h0, 32'h0000_0000, 1'b1}};

	load_setpoint_sequencer #(.EXT_TRIG_MIN_CYC(20)) DUT (
		.i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
		.o_prdata(prdata), .o_pslverr(pslverr), .i_key_trig(key_trig),
		.i_ext_trig(ext_trig), .o_setpoint(setpoint), .o_load_on(load_on));
	ext_trig_source u_src (.i_clk(i_clk), .i_go(ext_go), .i_width(ext_width), .o_trig(ext_trig));

	// ==========================================================================
	// Tasks
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Wait is open-ended; the watchdog ends a hang
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk);
		penable <= 1'b1;
		do @(posedge i_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task put(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task set_tran(input logic [15:0] a, ha, r, b, hb, f, input logic [31:0] c);
		put(`REG_CTRL, 32'h0);
		put(`REG_LEVEL_A, {16'h0, a});
		put(`REG_HOLD_A, {16'h0, ha});
		put(`REG_RISE, {16'h0, r});
		put(`REG_LEVEL_B, {16'h0, b});
		put(`REG_HOLD_B, {16'h0, hb});
		put(`REG_FALL, {16'h0, f});
		put(`REG_CTRL, c);
	endtask

	task fire(input int s, input logic [31:0] c);
		if (s == 0) begin
			key_trig <= 1'b1;
			repeat (2) @(posedge i_clk);
			key_trig <= 1'b0;
		end else if (s == 1) begin
			ext_width <= 16'd30;
			ext_go <= 1'b1;
			@(posedge i_clk);
			ext_go <= 1'b0;
		end else begin
			put(`REG_CTRL, c | 32'h8);
		end
	endtask

	task wait_sp(input logic [15:0] v);
		for (waited = 0; waited < 3 * TK && setpoint !== v; waited++) @(posedge i_clk);
		check({16'h0, setpoint}, {16'h0, v});
	endtask

	// ==========================================================================
	// Clock, watchdog and main sequence
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	initial begin
		repeat (100000) @(posedge i_clk);
		n_mismatch++;
		report_and_stop;
	end

	initial begin
		i_rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
		pwdata = 32'h0; key_trig = 1'b0; ext_go = 1'b0; ext_width = 16'h0000;
		repeat (8) @(posedge i_clk);
		i_rst_b <= 1'b1;
		@(posedge i_clk);
		check({15'h0, load_on, setpoint}, 32'h0);
		foreach (rows[i]) begin
			apb(rows[i].wr, rows[i].a, rows[i].d);
			if (!rows[i].wr) check(rd, rows[i].x);
			check({31'h0, er}, {31'h0, rows[i].e});
		end
		// Square wave: one tick per level
		set_tran(16'h0100, 16'h1, 16'h0, 16'h0900, 16'h1, 16'h0, 32'h1);
		wait_sp(16'h0900);
		wait_sp(16'h0100);
		t = waited;
		wait_sp(16'h0900);
		t += waited;
		check({31'h0, t >= 2 * TK && t <= 2 * TK + 4}, 32'h1);
		// Triangle: staircase of four ticks
		set_tran(16'h0000, 16'h0, 16'h4, 16'h0400, 16'h0, 16'h4, 32'h1);
		wait_sp(16'h0100);
		repeat (TK / 2) @(posedge i_clk);
		for (int k = 1; k <= 4; k++) begin
			check({16'h0, setpoint}, 32'(k * 256));
			repeat (TK) @(posedge i_clk);
		end
		// Pulse mode from each trigger source, then a runt pulse
		set_tran(16'h0100, 16'h1, 16'h0, 16'h0900, 16'h1, 16'h0, 32'h11);
		for (int s = 0; s < 3; s++) begin
			fire(s, 32'h11);
			wait_sp(16'h0900);
			repeat (TK + 100) @(posedge i_clk);
			check({16'h0, setpoint}, 32'h0100);
		end
		ext_width <= 16'd10;
		ext_go <= 1'b1;
		@(posedge i_clk);
		ext_go <= 1'b0;
		repeat (40) @(posedge i_clk);
		check({16'h0, setpoint}, 32'h0100);
		// Toggle mode keeps each level until the next trigger
		set_tran(16'h0100, 16'h1, 16'h0, 16'h0900, 16'h1, 16'h0, 32'h21);
		fire(0, 32'h21);
		wait_sp(16'h0900);
		repeat (TK + TK / 2) @(posedge i_clk);
		check({16'h0, setpoint}, 32'h0900);
		fire(2, 32'h21);
		wait_sp(16'h0100);
		// Trapezoid; a trigger during hold B must not shorten it
		set_tran(16'h0000, 16'h1, 16'h2, 16'h0200, 16'h1, 16'h2, 32'h1);
		wait_sp(16'h0100);
		wait_sp(16'h0200);
		fire(2, 32'h1);
		wait_sp(16'h0100);
		check({31'h0, waited >= 2 * TK - 8 && waited <= 2 * TK}, 32'h1);
		// List in slot 3: three steps stored, two counted
		put(`REG_CTRL, 32'h300);
		put(`REG_STEP_IDX, 32'h0);
		put(`REG_STEP_DATA, 32'h0001_0111);
		put(`REG_STEP_DATA, 32'h0001_0222);
		put(`REG_STEP_DATA, 32'h0001_0333);
		apb(1'b0, `REG_SLOT_KIND, 32'h0);
		check({31'h0, rd[3]}, 32'h1);
		for (int m = 0; m < 3; m++) begin
			put(`REG_LIST_CFG, 32'h0200_0001 | (32'(m) << 16));
			put(`REG_CTRL, 32'h302);
			wait_sp(16'h0111);
			check({31'h0, load_on}, 32'h1);
			// First step ends at a free-running tick, so time from the second step
			wait_sp(16'h0222);
			repeat (TK / 2) @(posedge i_clk);
			check({16'h0, setpoint}, 32'h0222);
			repeat (TK) @(posedge i_clk);
			if (m == 0) check({16'h0, setpoint}, 32'h0111);
			if (m == 1) check({15'h0, load_on, setpoint}, 32'h1_0222);
			if (m == 2) check({31'h0, load_on}, 32'h0);
			put(`REG_CTRL, 32'h304);
		end
		report_and_stop;
	end
endmodule
